// >>> bench/test_tmoc_top.sv
// self-checking bench for the compare-output block
`timescale 1ns/1ns
`default_nettype none
module test_tmoc_top;
  logic clk_sys_in = 0, sys_rst_in = 1, wr = 0, rd = 0, tick = 0;
  logic [7:0] addr = 0, wdata = 0, cm = 8'b01_01_10_11;
  logic [3:0] ex = 4'b0101;
  logic [1:0] sdata = 0, sdir = 0;
  wire [7:0] rdata;
  wire [1:0] pin, oe_n, pdata, pdir, lvl;
  wire fa, fb;
  logic [3:0] nfa = 0, nfb = 0;
  int n_fail = 0, compares = 0;
  always #25 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) if (fa) nfa <= nfa + 4'h1;
  always @(posedge clk_sys_in) if (fb) nfb <= nfb + 4'h1;
  tmoc_top dut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .timer_tick_enable_in(tick), .port_data_in(pdata), .port_dir_in(pdir), .pin_out(pin),
    .pin_oe_n_out(oe_n), .match_flag_a_out(fa), .match_flag_b_out(fb));
  tmoc_port_model port (.pin_in(pin), .oe_n_in(oe_n), .set_data_in(sdata),
    .set_dir_in(sdir), .port_data_out(pdata), .port_dir_out(pdir), .level_out(lvl));
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task wr8(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in) {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge clk_sys_in) wr <= 0;
  endtask
  // read data stand only in the cycle after the strobe
  task rd8(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    @(posedge clk_sys_in) {addr, rd} <= {a, 1'b1};
    @(posedge clk_sys_in) rd <= 0;
    #1 chk(rdata & m, exp);
  endtask
  // one tick per clock for n clocks
  task run(input int n);
    @(posedge clk_sys_in) tick <= 1;
    repeat (n - 1) @(posedge clk_sys_in);
    @(posedge clk_sys_in) tick <= 0;
  endtask
  task finish_test;
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #1000000;
    n_fail++;
    finish_test;
  end
  initial begin
    repeat (3) @(posedge clk_sys_in);
    sys_rst_in <= 0;
    rd8(8'h24, 8'hff, 8'h00);
    wr8(8'h24, 8'hff);
    rd8(8'h24, 8'hff, 8'hf3);
    rd8(8'h30, 8'hff, 8'h00);
    wr8(8'h24, 8'h00);
    @(posedge clk_sys_in) {sdata, sdir} <= 4'b10_11;
    repeat (3) @(posedge clk_sys_in);
    #1 chk({4'h0, oe_n, lvl}, 8'h02);
    @(posedge clk_sys_in) {sdata, sdir} <= 4'b10_00;
    repeat (3) @(posedge clk_sys_in);
    #1 chk({4'h0, oe_n, lvl}, 8'h0d);
    @(posedge clk_sys_in) {sdata, sdir} <= 4'b00_11;
    $display("port test done");
    wr8(8'h27, 8'h05);
    wr8(8'h28, 8'h09);
    for (int i = 0; i < 4; i++) begin
      wr8(8'h24, {cm[2*i+:2], cm[2*i+:2], 4'h0});
      run(256);
      rd8(8'h29, 8'h03, {6'h0, ex[i], ex[i]});
      chk({6'h0, pin}, {6'h0, ex[i], ex[i]});
    end
    chk({nfa, nfb}, 8'h44);
    $display("normal mode test done");
    wr8(8'h24, 8'he3);
    run(6);
    rd8(8'h29, 8'h03, 8'h01);
    run(250);
    rd8(8'h29, 8'h03, 8'h02);
    run(10);
    rd8(8'h29, 8'h03, 8'h01);
    wr8(8'h24, 8'hd3);
    run(256);
    rd8(8'h29, 8'h03, 8'h01);
    wr8(8'h27, 8'hff);
    wr8(8'h24, 8'hc3);
    run(256);
    rd8(8'h29, 8'h01, 8'h00);
    $display("fast pwm test done");
    @(posedge clk_sys_in) sys_rst_in <= 1;
    @(posedge clk_sys_in) sys_rst_in <= 0;
    rd8(8'h24, 8'hff, 8'h00);
    wr8(8'h27, 8'h05);
    wr8(8'h28, 8'h09);
    wr8(8'h24, 8'hb1);
    run(10);
    rd8(8'h29, 8'h03, 8'h02);
    run(500);
    rd8(8'h29, 8'h03, 8'h01);
    $display("dual slope test done");
    wr8(8'h25, 8'h01);
    wr8(8'h24, 8'h43);
    run(6);
    rd8(8'h29, 8'h01, 8'h00);
    rd8(8'h26, 8'hff, 8'h00);
    $display("toggle pwm test done");
    finish_test;
  end
endmodule // test_tmoc_top
`default_nettype wire

// >>> bench/tmoc_port_model.sv
// port pin model: data and direction bits and the resolved pin level
`timescale 1ns/1ns
`default_nettype none
module tmoc_port_model (
  input wire logic [1:0] pin_in,
  input wire logic [1:0] oe_n_in,
  input wire logic [1:0] set_data_in,
  input wire logic [1:0] set_dir_in,
  output logic [1:0] port_data_out,
  output logic [1:0] port_dir_out,
  output logic [1:0] level_out
);
  assign port_data_out = set_data_in;
  assign port_dir_out = set_dir_in;
  // undriven pin shows the inverse so a stale level never passes
  assign level_out = pin_in ^ oe_n_in;
endmodule // tmoc_port_model
`default_nettype wire

// >>> bench/tmoc_top_sva.sv
// port-level assertions for the compare-output block
`timescale 1ns/1ns
`default_nettype none
`include "tmoc_defines.vh"
module tmoc_top_sva (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic timer_tick_enable_in,
  input wire logic [1:0] port_data_in,
  input wire logic [1:0] port_dir_in,
  input wire logic [1:0] pin_out,
  input wire logic [1:0] pin_oe_n_out,
  input wire logic match_flag_a_out,
  input wire logic match_flag_b_out
);
  // shadow of the control register, rebuilt from bus writes
  logic [7:0] sh;
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) sh <= 8'h00;
    else if (reg_wr_in && reg_addr_in == `TMOC_OFS_CTRL) sh <= reg_wdata_in;
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  a_oe_from_dir: assert property (
    !$past(sys_rst_in) |-> pin_oe_n_out == ~$past(port_dir_in)) else $error("oe wrong");
  a_port_pass_a: assert property (
    !$past(sys_rst_in) && $past(sh[7:6]) == 2'h0 |-> pin_out[0] == $past(port_data_in[0]))
    else $error("pin a not port");
  a_port_pass_b: assert property (
    !$past(sys_rst_in) && $past(sh[5:4]) == 2'h0 |-> pin_out[1] == $past(port_data_in[1]))
    else $error("pin b not port");
  a_ctrl_read: assert property (
    $past(reg_rd_in) && $past(reg_addr_in) == `TMOC_OFS_CTRL
    |-> reg_rdata_out == ($past(sh) & `TMOC_CTRL_WMASK)) else $error("ctrl read wrong");
  a_flag_a_tick: assert property (match_flag_a_out |-> $past(timer_tick_enable_in))
    else $error("flag a without tick");
  a_flag_b_tick: assert property (match_flag_b_out |-> $past(timer_tick_enable_in))
    else $error("flag b without tick");
  a_hold_a: assert property (
    !$past(sys_rst_in, 2) && !$past(timer_tick_enable_in, 2) && $past(sh, 2) == $past(sh)
    && $past(sh[7:6]) != 2'h0 |-> $stable(pin_out[0])) else $error("pin a moved");
  a_hold_b: assert property (
    !$past(sys_rst_in, 2) && !$past(timer_tick_enable_in, 2) && $past(sh, 2) == $past(sh)
    && $past(sh[5:4]) != 2'h0 |-> $stable(pin_out[1])) else $error("pin b moved");
endmodule // tmoc_top_sva
bind tmoc_top tmoc_top_sva chk (.*);
`default_nettype wire

// >>> core/tmoc_defines.vh
// register map, reset value, write mask and mode codes for the compare-output block
`ifndef TMOC_DEFINES_VH
`define TMOC_DEFINES_VH
`define TMOC_ADDR_W 8
`define TMOC_OFS_CTRL 8'h24
`define TMOC_OFS_WAVE_HI 8'h25
`define TMOC_OFS_CMP_A 8'h27
`define TMOC_OFS_CMP_B 8'h28
`define TMOC_OFS_COUNT 8'h26
`define TMOC_OFS_STATUS 8'h29
`define TMOC_CTRL_RST 8'h00
`define TMOC_CTRL_WMASK 8'hf3
`define TMOC_MAX 8'hff
`define TMOC_BOTTOM 8'h00
`define TMOC_MODE_NORMAL 3'h0
`define TMOC_MODE_PC_FF 3'h1
`define TMOC_MODE_CTC 3'h2
`define TMOC_MODE_FAST_FF 3'h3
`define TMOC_MODE_PC_CA 3'h5
`define TMOC_MODE_FAST_CA 3'h7
`define TMOC_COM_OFF 2'h0
`define TMOC_COM_TOG 2'h1
`define TMOC_COM_CLR 2'h2
`define TMOC_COM_SET 2'h3
`endif

// >>> core/tmoc_top.v
// 8-bit timer with two compare channels and compare-output mode control
`timescale 1ns/1ns
`default_nettype none
`include "tmoc_defines.vh"
module tmoc_top (
  // clock and reset
  input wire clk_sys_in,
  input wire sys_rst_in,
  // register port
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [7:0] reg_rdata_out,
  // timer tick from the prescaler, same clock domain
  input wire timer_tick_enable_in,
  // port pin data and direction from the port block
  input wire [1:0] port_data_in,
  input wire [1:0] port_dir_in,
  // pins: index 0 wave_out_a, index 1 wave_out_b; oe low means driving
  output reg [1:0] pin_out,
  output reg [1:0] pin_oe_n_out,
  // compare match pulses
  output reg match_flag_a_out,
  output reg match_flag_b_out
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [7:0] timer0_output_and_wave_control;
  reg wave_mode_hi_bit;
  reg [7:0] compare_value_a;
  reg [7:0] compare_value_b;
  reg [7:0] count_value;
  reg count_down;
  reg wave_out_a;
  reg wave_out_b;

  wire [1:0] chan_a_output_mode = timer0_output_and_wave_control[7:6];
  wire [1:0] chan_b_output_mode = timer0_output_and_wave_control[5:4];
  wire [1:0] wave_mode_low_bits = timer0_output_and_wave_control[1:0];
  wire [2:0] wave_mode_sel = {wave_mode_hi_bit, wave_mode_low_bits};

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  wire mode_fast = (wave_mode_sel == `TMOC_MODE_FAST_FF) ||
                   (wave_mode_sel == `TMOC_MODE_FAST_CA);
  wire mode_pc = (wave_mode_sel == `TMOC_MODE_PC_FF) ||
                 (wave_mode_sel == `TMOC_MODE_PC_CA);
  wire mode_ctc = (wave_mode_sel == `TMOC_MODE_CTC);
  wire top_is_cmp = mode_ctc || (wave_mode_sel == `TMOC_MODE_PC_CA) ||
                    (wave_mode_sel == `TMOC_MODE_FAST_CA);
  wire [7:0] top_value = top_is_cmp ? compare_value_a : `TMOC_MAX;
  wire at_top = (count_value == top_value);
  wire at_bottom = (count_value == `TMOC_BOTTOM);

  // next output level for one channel; allow_tog separates a from b
  function [1:0] chan_next; // {drive_change, value}
    input [1:0] mode;
    input cur;
    input match;
    input [7:0] cmp;
    input allow_tog;
    reg hit;
    begin
      chan_next = {1'b0, cur};
      hit = match;
      if ((mode_fast || mode_pc) && mode[1] && (cmp == top_value))
        hit = 1'b0;
      if (!(mode_fast || mode_pc)) begin
        if (hit) begin
          case (mode)
            `TMOC_COM_TOG: chan_next = {1'b1, ~cur};
            `TMOC_COM_CLR: chan_next = 2'b10;
            `TMOC_COM_SET: chan_next = 2'b11;
            default: chan_next = {1'b0, cur};
          endcase
        end
      end else if (mode == `TMOC_COM_TOG) begin
        // toggle only for channel a with the high wave bit
        if (hit && allow_tog && wave_mode_hi_bit)
          chan_next = {1'b1, ~cur};
      end else if (mode[1]) begin
        if (mode_fast) begin
          if (hit)
            chan_next = {1'b1, mode[0]};
          else if (at_top)
            chan_next = {1'b1, ~mode[0]};
        end else begin
          // dual slope: the top case still acts as the down-match level
          if (hit)
            chan_next = {1'b1, count_down ? ~mode[0] : mode[0]};
          else if (mode[1] && (cmp == top_value) && at_top)
            chan_next = {1'b1, ~mode[0]};
        end
      end
    end
  endfunction

  // compare hit, shared by the wave logic and the match pulses
  function same8;
    input [7:0] lhs;
    input [7:0] rhs;
    begin
      same8 = (lhs == rhs);
    end
  endfunction

  // a channel owns its pin whenever its mode field is nonzero
  function owns_pin;
    input [1:0] mode;
    begin
      owns_pin = (mode != `TMOC_COM_OFF);
    end
  endfunction

  wire match_a = same8(count_value, compare_value_a);
  wire match_b = same8(count_value, compare_value_b);
  wire [1:0] next_a = chan_next(chan_a_output_mode, wave_out_a, match_a,
                                compare_value_a, 1'b1);
  wire [1:0] next_b = chan_next(chan_b_output_mode, wave_out_b, match_b,
                                compare_value_b, 1'b0);

  // ----------------------------------------------------------------
  // counter next state
  // ----------------------------------------------------------------
  reg [7:0] next_count_value;
  reg next_count_down;
  reg next_wave_out_a;
  reg next_wave_out_b;

  // tick is a plain enable term here, so no second clock domain exists
  always @* begin
    next_count_value = count_value;
    next_count_down = count_down;
    next_wave_out_a = wave_out_a;
    next_wave_out_b = wave_out_b;
    if (timer_tick_enable_in) begin
      next_wave_out_a = next_a[0];
      next_wave_out_b = next_b[0];
      if (mode_pc) begin
        // dual slope turns at top and bottom; top lasts one tick
        if (at_top)
          next_count_down = 1'b1;
        else if (at_bottom)
          next_count_down = 1'b0;
        if ((at_top && !count_down) || (count_down && !at_bottom))
          next_count_value = count_value - 8'h01;
        else
          next_count_value = count_value + 8'h01;
      end else begin
        next_count_down = 1'b0;
        // normal mode wraps at max by itself
        if (at_top && (mode_ctc || mode_fast))
          next_count_value = `TMOC_BOTTOM;
        else
          next_count_value = count_value + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // counter and waveform state
  // ----------------------------------------------------------------
  // loaded on every edge; idle cycles simply reload the old value
  always @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      count_value <= 8'h00;
      count_down <= 1'b0;
      wave_out_a <= 1'b0;
      wave_out_b <= 1'b0;
    end else begin
      count_value <= next_count_value;
      count_down <= next_count_down;
      wave_out_a <= next_wave_out_a;
      wave_out_b <= next_wave_out_b;
    end
  end

  // ----------------------------------------------------------------
  // match pulses and pin mux
  // ----------------------------------------------------------------
  reg [1:0] next_pin_out;
  reg [1:0] next_pin_oe_n_out;
  reg next_match_flag_a;
  reg next_match_flag_b;

  always @* begin
    next_match_flag_a = timer_tick_enable_in && match_a;
    next_match_flag_b = timer_tick_enable_in && match_b;
    // override only when the mode field is nonzero
    next_pin_out[0] = owns_pin(chan_a_output_mode) ? wave_out_a : port_data_in[0];
    next_pin_out[1] = owns_pin(chan_b_output_mode) ? wave_out_b : port_data_in[1];
    // driver enable follows direction alone, never the mode field
    next_pin_oe_n_out = ~port_dir_in;
  end

  // pins lag the wave state by one cycle so every output is a flop
  always @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      match_flag_a_out <= 1'b0;
      match_flag_b_out <= 1'b0;
      pin_out <= 2'h0;
      pin_oe_n_out <= 2'h3;
    end else begin
      match_flag_a_out <= next_match_flag_a;
      match_flag_b_out <= next_match_flag_b;
      pin_out <= next_pin_out;
      pin_oe_n_out <= next_pin_oe_n_out;
    end
  end

  // ----------------------------------------------------------------
  // register port, write side
  // ----------------------------------------------------------------
  reg [7:0] next_timer0_output_and_wave_control;
  reg next_wave_mode_hi_bit;
  reg [7:0] next_compare_value_a;
  reg [7:0] next_compare_value_b;

  // reserved bits are masked on the way in so they never read back set
  always @* begin
    next_timer0_output_and_wave_control = timer0_output_and_wave_control;
    next_wave_mode_hi_bit = wave_mode_hi_bit;
    next_compare_value_a = compare_value_a;
    next_compare_value_b = compare_value_b;
    if (reg_wr_in) begin
      case (reg_addr_in)
        `TMOC_OFS_CTRL:
          next_timer0_output_and_wave_control = reg_wdata_in & `TMOC_CTRL_WMASK;
        `TMOC_OFS_WAVE_HI: next_wave_mode_hi_bit = reg_wdata_in[0];
        `TMOC_OFS_CMP_A: next_compare_value_a = reg_wdata_in;
        `TMOC_OFS_CMP_B: next_compare_value_b = reg_wdata_in;
        default: ;
      endcase
    end
  end

  // compare values act at once; no buffering up to top
  always @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      timer0_output_and_wave_control <= `TMOC_CTRL_RST;
      wave_mode_hi_bit <= 1'b0;
      compare_value_a <= 8'h00;
      compare_value_b <= 8'h00;
    end else begin
      timer0_output_and_wave_control <= next_timer0_output_and_wave_control;
      wave_mode_hi_bit <= next_wave_mode_hi_bit;
      compare_value_a <= next_compare_value_a;
      compare_value_b <= next_compare_value_b;
    end
  end

  // ----------------------------------------------------------------
  // register port, read side
  // ----------------------------------------------------------------
  reg [7:0] next_reg_rdata;

  // data stand for one cycle only; idle cycles read zero
  always @* begin
    next_reg_rdata = 8'h00;
    if (reg_rd_in) begin
      case (reg_addr_in)
        `TMOC_OFS_CTRL: next_reg_rdata = timer0_output_and_wave_control;
        `TMOC_OFS_WAVE_HI: next_reg_rdata = {7'h00, wave_mode_hi_bit};
        `TMOC_OFS_CMP_A: next_reg_rdata = compare_value_a;
        `TMOC_OFS_CMP_B: next_reg_rdata = compare_value_b;
        `TMOC_OFS_COUNT: next_reg_rdata = count_value;
        // status lets software see direction and both wave levels
        `TMOC_OFS_STATUS: next_reg_rdata = {5'h00, count_down, wave_out_b, wave_out_a};
        default: next_reg_rdata = 8'h00;
      endcase
    end
  end

  always @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= 8'h00;
    end else begin
      reg_rdata_out <= next_reg_rdata;
    end
  end

endmodule // tmoc_top
`default_nettype wire
